// ### hdl/stp_defines.vh
`ifndef STP_DEFINES_VH
`define STP_DEFINES_VH
// Register byte offsets (word aligned)
`define STP_OFF_PERIOD    8'h00
`define STP_OFF_TBCTRL    8'h04
`define STP_OFF_COUNT     8'h08
`define STP_OFF_FLAGS     8'h0c
`define STP_OFF_PINCTRL   8'h10
`define STP_OFF_CH_BASE   8'h20
`define STP_CH_STRIDE     4
// Per-channel word index within a channel group
`define STP_CH_CTRL       2'd0
`define STP_CH_DHIGH      2'd1
`define STP_CH_DLOW       2'd2
// timebase_control fields
`define STP_TB_PS_LSB     0
`define STP_TB_RUN_BIT    2
`define STP_TB_POST_LSB   3
// channel_control fields
`define STP_CC_EN_BIT     7
`define STP_CC_OE_BIT     6
`define STP_CC_OUT_BIT    5
`define STP_CC_POL_BIT    4
// flags
`define STP_FLAG_MATCH    0
// Reset values
`define STP_RST_PERIOD    8'hff
`define STP_RST_TBCTRL    8'h00
`define STP_RST_CCTRL     8'h00
`define STP_RST_DUTY      8'h00
`define STP_RST_DIR       8'hff
// Sub-count maximum of the 10-bit time base
`define STP_SUB_MAX       2'd3
`endif

// ### hdl/stp_prescaler.v
`timescale 1ns/1ps
`include "stp_defines.vh"
module stp_prescaler (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // Control
  input  wire       i_run,
  input  wire [1:0] i_sel,
  // Tick out
  output wire       o_tick
);
  reg  [5:0] cnt_ff;
  reg  [5:0] nxt_cnt;
  reg  [5:0] limit;

  always @* begin
    case (i_sel)
      2'd0:    limit = 6'h00;
      2'd1:    limit = 6'h03;
      2'd2:    limit = 6'h0f;
      default: limit = 6'h3f;
    endcase
  end

  // Tick every 1, 4, 16 or 64 clocks while running
  assign o_tick = i_run && (cnt_ff >= limit);

  always @* begin
    nxt_cnt = cnt_ff;
    if (i_run) begin
      if (cnt_ff >= limit)
        nxt_cnt = 6'h00;
      else
        nxt_cnt = cnt_ff + 6'h01;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      cnt_ff <= 6'h00;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule // stp_prescaler

// ### hdl/stp_pwm.v
// Notes on behaviour
// - Ten-bit duty compared to ten-bit time base
// - One shared period, independent duty per channel
// - Outputs go active when count clears, unless duty is zero
// - Output inactive when time base equals duty
// - Duty at or above 4x period limit: always active
// - Comparator uses buffer reloaded at period match
// - Polarity bit inverts channel output
// - Period is (limit+1)*4*clock*prescale
// - After match: clear, activate unless zero, load
// - Postscaler setting never affects PWM
// - Duty writes accepted anytime, take effect later
// - Time base is count plus 2-bit subcount
// - Resolution follows period limit, ten bits at 255
// - Sleep freezes counting, state and pins
// - Reset restores registers, pins to input
// - Cleared output enable hands pin to latch
// - PWM frequency tracks system clock directly
`timescale 1ns/1ps
`include "stp_defines.vh"
module stp_pwm #(
  parameter NCH = 4
) (
  // Clock and reset
  input  wire           I_CLOCK,
  input  wire           I_SYS_RST,
  // AHB-Lite slave
  input  wire           I_HSEL,
  input  wire [7:0]     I_HADDR,
  input  wire [1:0]     I_HTRANS,
  input  wire           I_HWRITE,
  input  wire [2:0]     I_HSIZE,
  input  wire [31:0]    I_HWDATA,
  input  wire           I_HREADY,
  output wire [31:0]    O_HRDATA,
  output wire           O_HREADYOUT,
  output wire           O_HRESP,
  // Power
  input  wire           I_SLEEP,
  // Pins
  output wire [NCH-1:0] O_PWM_PIN,
  output wire [NCH-1:0] O_PWM_PIN_OE,
  output wire [NCH-1:0] O_PWM_OUT
);
  reg  [7:0]     period_limit_ff;
  reg  [7:0]     tb_ctrl_ff;
  reg  [7:0]     tb_count_ff;
  reg  [1:0]     sub_ff;
  reg            match_flag_ff;
  reg  [NCH-1:0] pin_dir_ff;
  reg  [NCH-1:0] port_latch_ff;
  reg  [7:0]     cctrl_ff [0:NCH-1];
  reg  [7:0]     dhigh_ff [0:NCH-1];
  reg  [1:0]     dlow_ff  [0:NCH-1];
  reg  [9:0]     dbuf_ff  [0:NCH-1];
  reg  [NCH-1:0] out_ff;
  reg  [NCH-1:0] pin_ff;
  reg  [NCH-1:0] pin_oe_ff;
  reg            wr_pend_ff;
  reg  [7:0]     wr_addr_ff;
  reg  [31:0]    rdata_ff;
  reg  [31:0]    nxt_rdata;
  wire           tick;
  wire           run;
  wire           sub_wrap;
  wire           period_match;
  wire [9:0]     time_base;
  wire           addr_ok;
  integer        i;

  function [31:0] ch_addr;
    input integer ch;
    input [1:0]   idx;
    begin
      ch_addr = {24'h000000, `STP_OFF_CH_BASE} + ch * 16 + idx * `STP_CH_STRIDE;
    end
  endfunction

  // Sleep gates the prescaler so every counter freezes in place
  assign run = tb_ctrl_ff[`STP_TB_RUN_BIT] && !I_SLEEP;

  stp_prescaler u_pre (
    .i_clk  (I_CLOCK),
    .i_rst  (I_SYS_RST),
    .i_run  (run),
    .i_sel  (tb_ctrl_ff[`STP_TB_PS_LSB +: 2]),
    .o_tick (tick)
  );

  // Postscaler bits are stored only; nothing below but the bus readback reads them
  // Time base counts prescaler ticks, not system clocks
  assign time_base    = {tb_count_ff, sub_ff};
  assign sub_wrap     = tick && (sub_ff == `STP_SUB_MAX);
  // Period = (limit+1) counts of 4 prescaled clocks
  assign period_match = sub_wrap && (tb_count_ff == period_limit_ff);

  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tb_count_ff <= 8'h00;
      sub_ff      <= 2'd0;
    end else if (tick) begin
      sub_ff <= sub_ff + 2'd1;
      if (period_match)
        tb_count_ff <= 8'h00;
      else if (sub_wrap)
        tb_count_ff <= tb_count_ff + 8'h01;
    end
  end

  // Channel logic, identical per channel
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (i = 0; i < NCH; i = i + 1) begin
        dbuf_ff[i] <= 10'h000;
        out_ff[i]  <= 1'b0;
      end
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        if (period_match) begin
          // Buffer reload; writes before this are invisible
          dbuf_ff[i] <= {dhigh_ff[i], dlow_ff[i]};
          // Active at wrap unless the new duty is zero
          out_ff[i]  <= ({dhigh_ff[i], dlow_ff[i]} != 10'h000);
        end else if (tick && (time_base + 10'h001 == dbuf_ff[i]) &&
                     (dbuf_ff[i][9:2] < period_limit_ff)) begin
          // Clear on equality; duty >= 4*limit never clears
          out_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Pin mux: polarity, output enable and direction
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pin_ff    <= {NCH{1'b0}};
      pin_oe_ff <= {NCH{1'b0}};
    end else if (!I_SLEEP) begin
      for (i = 0; i < NCH; i = i + 1) begin
        pin_oe_ff[i] <= !pin_dir_ff[i];
        if (cctrl_ff[i][`STP_CC_OE_BIT] && cctrl_ff[i][`STP_CC_EN_BIT])
          pin_ff[i] <= out_ff[i] ^ cctrl_ff[i][`STP_CC_POL_BIT];
        else
          pin_ff[i] <= port_latch_ff[i];
      end
    end
  end

  assign O_PWM_PIN    = pin_ff;
  assign O_PWM_PIN_OE = pin_oe_ff;
  assign O_PWM_OUT    = out_ff;

  // AHB-Lite: zero wait states, OKAY always
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  assign O_HRDATA    = rdata_ff;
  assign addr_ok     = I_HSEL && I_HREADY && I_HTRANS[1];

  always @* begin
    nxt_rdata = 32'h00000000;
    case (I_HADDR)
      `STP_OFF_PERIOD:  nxt_rdata = {24'h000000, period_limit_ff};
      `STP_OFF_TBCTRL:  nxt_rdata = {24'h000000, 1'b0, tb_ctrl_ff[6:0]};
      `STP_OFF_COUNT:   nxt_rdata = {24'h000000, tb_count_ff};
      `STP_OFF_FLAGS:   nxt_rdata = {31'h00000000, match_flag_ff};
      // Latch bits read back at the same position that a write takes them from
      `STP_OFF_PINCTRL: nxt_rdata = {{(24 - NCH){1'b0}}, port_latch_ff,
                                     {(8 - NCH){1'b0}}, pin_dir_ff};
      default: begin
        for (i = 0; i < NCH; i = i + 1) begin
          if ({24'h000000, I_HADDR} == ch_addr(i, `STP_CH_CTRL))
            nxt_rdata = {24'h000000, cctrl_ff[i][7:6],
                         out_ff[i] ^ cctrl_ff[i][`STP_CC_POL_BIT],
                         cctrl_ff[i][4], 4'h0};
          if ({24'h000000, I_HADDR} == ch_addr(i, `STP_CH_DHIGH))
            nxt_rdata = {24'h000000, dhigh_ff[i]};
          if ({24'h000000, I_HADDR} == ch_addr(i, `STP_CH_DLOW))
            nxt_rdata = {24'h000000, dlow_ff[i], 6'h00};
        end
      end
    endcase
  end

  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h00000000;
    end else begin
      wr_pend_ff <= addr_ok && I_HWRITE;
      if (addr_ok)
        wr_addr_ff <= I_HADDR;
      if (addr_ok && !I_HWRITE)
        rdata_ff <= nxt_rdata;
    end
  end

  // Register writes in the data phase; duty writes allowed any time
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      period_limit_ff <= `STP_RST_PERIOD;
      tb_ctrl_ff      <= `STP_RST_TBCTRL;
      match_flag_ff   <= 1'b0;
      pin_dir_ff      <= {NCH{1'b1}};
      port_latch_ff   <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        cctrl_ff[i] <= `STP_RST_CCTRL;
        dhigh_ff[i] <= `STP_RST_DUTY;
        dlow_ff[i]  <= 2'd0;
      end
    end else begin
      // Set wins over a same-cycle software clear
      if (period_match)
        match_flag_ff <= 1'b1;
      else if (wr_pend_ff && wr_addr_ff == `STP_OFF_FLAGS && I_HWDATA[`STP_FLAG_MATCH])
        match_flag_ff <= 1'b0;
      if (wr_pend_ff) begin
        case (wr_addr_ff)
          `STP_OFF_PERIOD:  period_limit_ff <= I_HWDATA[7:0];
          `STP_OFF_TBCTRL:  tb_ctrl_ff <= {1'b0, I_HWDATA[6:0]};
          `STP_OFF_PINCTRL: begin
            pin_dir_ff    <= I_HWDATA[NCH-1:0];
            port_latch_ff <= I_HWDATA[8+NCH-1:8];
          end
          default: begin
            for (i = 0; i < NCH; i = i + 1) begin
              if ({24'h000000, wr_addr_ff} == ch_addr(i, `STP_CH_CTRL))
                cctrl_ff[i] <= {I_HWDATA[7:6], 1'b0, I_HWDATA[4], 4'h0};
              if ({24'h000000, wr_addr_ff} == ch_addr(i, `STP_CH_DHIGH))
                dhigh_ff[i] <= I_HWDATA[7:0];
              if ({24'h000000, wr_addr_ff} == ch_addr(i, `STP_CH_DLOW))
                dlow_ff[i] <= I_HWDATA[7:6];
            end
          end
        endcase
      end
    end
  end
endmodule // stp_pwm

// ### verification/stp_load_model.sv
`timescale 1ns/1ps
module stp_load_model #(
  parameter int NCH = 4
) (
  // Pins from the generator
  input  wire logic [NCH-1:0] i_pin,
  input  wire logic [NCH-1:0] i_oe,
  // Level seen by the load
  output wire logic [NCH-1:0] o_level
);
  // A released pin is pulled low, so a stale driven value never lingers
  assign o_level = i_pin & i_oe;
endmodule // stp_load_model

// ### verification/stp_pwm_sva.sv
`timescale 1ns/1ps
module stp_pwm_sva #(
  parameter NCH = 4
) (
  // Clock and reset
  input wire           I_CLOCK,
  input wire           I_SYS_RST,
  // Bus
  input wire           I_HSEL,
  input wire [7:0]     I_HADDR,
  input wire [1:0]     I_HTRANS,
  input wire           I_HWRITE,
  input wire [2:0]     I_HSIZE,
  input wire [31:0]    I_HWDATA,
  input wire           I_HREADY,
  input wire [31:0]    O_HRDATA,
  input wire           O_HREADYOUT,
  input wire           O_HRESP,
  // Power and pins
  input wire           I_SLEEP,
  input wire [NCH-1:0] O_PWM_PIN,
  input wire [NCH-1:0] O_PWM_PIN_OE,
  input wire [NCH-1:0] O_PWM_OUT
);
  wire wr_a = I_HSEL & I_HREADY & I_HTRANS[1] & I_HWRITE;
  wire rd_a = I_HSEL & I_HREADY & I_HTRANS[1] & ~I_HWRITE;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_nap; I_SLEEP ##1 I_SLEEP; endsequence
  // A register write reaches the pins two to four edges after its address phase
  sequence s_wrote; $past(wr_a, 2) || $past(wr_a, 3) || $past(wr_a, 4); endsequence
  property p_ready; O_HREADYOUT && !O_HRESP; endproperty
  property p_rd_hold; !rd_a |=> $stable(O_HRDATA); endproperty
  property p_rst_oe; $fell(I_SYS_RST) |-> O_PWM_PIN_OE == '0; endproperty
  property p_rst_out; $fell(I_SYS_RST) |-> O_PWM_OUT == '0 && O_PWM_PIN == '0; endproperty
  property p_oe_cause; $changed(O_PWM_PIN_OE) |-> s_wrote; endproperty
  property p_sleep_out; I_SLEEP |=> $stable(O_PWM_OUT); endproperty
  property p_sleep_pin; s_nap |-> $stable(O_PWM_PIN); endproperty
  property p_pin_cause;
    $changed(O_PWM_PIN) |-> s_wrote or ($past(O_PWM_OUT) != $past(O_PWM_OUT, 2));
  endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or errored");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_rst_oe: assert property (p_rst_oe) else $error("pin driven after reset");
  a_rst_out: assert property (p_rst_out) else $error("output not cleared");
  a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
  a_sleep_out: assert property (p_sleep_out) else $error("output moved asleep");
  a_sleep_pin: assert property (p_sleep_pin) else $error("pin moved asleep");
  a_pin_cause: assert property (p_pin_cause) else $error("pin moved alone");
endmodule // stp_pwm_sva

// ### verification/stp_pwm_tb_top.sv
`timescale 1ns/1ps
module stp_pwm_tb_top;
  localparam int NCH = 2;
  logic           clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, sleep = 1'b0;
  logic [7:0]     haddr = 8'h00;
  logic [1:0]     htrans = 2'h0;
  logic [31:0]    hwdata = 32'h0, rd_val;
  logic           rd_dp = 1'b0, lp = 1'b0;
  logic [9:0]     d;
  wire  [31:0]    hrdata;
  wire            hready;
  wire  [NCH-1:0] pin, oe, lvl;
  logic [32:0]    qr[$];
  int             qw[$];
  int             miscompares = 0;
  int             samples_checked = 0;
  int             cnt, n, sel, w;
  always #4 clk = ~clk;
  stp_pwm #(.NCH(NCH)) u_stp_pwm (.I_CLOCK(clk), .I_SYS_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(), .I_SLEEP(sleep),
    .O_PWM_PIN(pin), .O_PWM_PIN_OE(oe), .O_PWM_OUT());
  stp_load_model #(.NCH(NCH)) u_stp_load_model (.i_pin(pin), .i_oe(oe), .o_level(lvl));
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task hang;
    miscompares++;
    complete_run();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (rd_dp && qr.size() > 0) begin
      if (qr[0][32]) chk(hrdata, qr[0][31:0]);
      void'(qr.pop_front());
    end
    rd_dp <= hsel & htrans[1] & ~hwrite & hready;
  end
  // High time of channel 0 at the load, compared when the pulse ends
  always @(negedge clk) begin
    if (lvl[0]) cnt = lp ? cnt + 1 : 1;
    else if (lp && qw.size() > 0) chk(cnt, qw.pop_front());
    lp = lvl[0];
  end
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] note);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do begin @(posedge clk); k++; end while (!hready && k < 50);
    if (!wr) qr.push_back(note);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); k++; end while (!hready && k < 100);
    if (k >= 50) hang();
    rd_val = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {1'b1, e});
  endtask
  task duty(input logic [3:0] ch, input logic [9:0] v);
    wr({ch, 4'h0} + 8'h24, {24'h0, v[9:2]});
    wr({ch, 4'h0} + 8'h28, {24'h0, v[1:0], 6'h0});
  endtask
  task wait_rise;
    int k;
    logic p;
    k = 0;
    do begin p = lvl[0]; @(negedge clk); k++; end while ((p || !lvl[0]) && k < 20000);
    if (k >= 20000) hang();
    @(posedge clk);
  endtask
  task wait_empty;
    int k;
    k = 0;
    while (qw.size() > 0 && k < 20000) begin @(posedge clk); k++; end
    if (k >= 20000) hang();
  endtask
  task measure(input int e);
    repeat (3) wait_rise();
    qw.push_back(e);
    duty(0, 10'h3);
    wait_empty();
  endtask
  initial begin
    void'($urandom(1931));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 32'hff);
    rd(8'h04, 32'h0);
    wr(8'hfc, 32'h5a);
    rd(8'hfc, 32'h0);
    wr(8'h10, 32'hff);
    wr(8'h00, 32'h7);
    duty(0, 10'h0);
    wr(8'h0c, 32'h1);
    wr(8'h04, 32'h7c);
    n = 0;
    do begin xfer(1'b0, 8'h0c, 32'h0, 33'h0); n++; end while (!rd_val[0] && n < 100);
    if (n >= 100) hang();
    wr(8'h10, 32'h0);
    wr(8'h20, 32'hc0);
    wr(8'h30, 32'hc0);
    $display("setup test done");
    for (sel = 0; sel < 4; sel++) begin
      d = 10'($urandom_range(27, 2));
      duty(0, d);
      wr(8'h04, 32'h7c | 32'(sel));
      wr(8'h20, sel[0] ? 32'hd0 : 32'hc0);
      w = d << (2 * sel);
      measure(sel[0] ? (32 << (2 * sel)) - w : w);
      $display("prescale test %0d done", sel);
    end
    wr(8'h04, 32'h4);
    wr(8'h20, 32'hc0);
    duty(0, 10'h9);
    repeat (3) wait_rise();
    qw.push_back(109);
    sleep <= 1'b1;
    repeat (100) @(posedge clk);
    sleep <= 1'b0;
    wait_empty();
    $display("sleep test done");
    duty(1, 10'h1c);
    repeat (2) wait_rise();
    rd(8'h30, 32'he0);
    duty(1, 10'h0);
    repeat (2) wait_rise();
    rd(8'h30, 32'hc0);
    wr(8'h10, 32'h200);
    rd(8'h10, 32'h200);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 32'hff);
    rd(8'h30, 32'h0);
    $display("limits and reset test done");
    complete_run();
  end
endmodule // stp_pwm_tb_top
bind stp_pwm stp_pwm_sva #(.NCH(NCH)) u_stp_pwm_sva (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST),
  .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
  .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
  .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .I_SLEEP(I_SLEEP), .O_PWM_PIN(O_PWM_PIN),
  .O_PWM_PIN_OE(O_PWM_PIN_OE), .O_PWM_OUT(O_PWM_OUT));
